// [rtl/rcb_top.v]
/*
 * reset cause and behaviour controller: per-source reset type, sticky
 * reset causes, rail brownout flags, sleep control and sram size readback.
 * assumes an axi4-lite master, rst as the power-on reset and same-clock
 * request pulses from watchdogs and other system logic.
 */
`timescale 1ns/1ns
`include "rcb_defines.vh"
module rcb_top (
    input  wire                      mclk,
    input  wire                      rst,
    input  wire [`RCB_ADDR_W-1:0]    s_axi_awaddr,
    input  wire                      s_axi_awvalid,
    output wire                      s_axi_awready,
    input  wire [31:0]               s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output wire                      s_axi_wready,
    output wire [1:0]                s_axi_bresp,
    output wire                      s_axi_bvalid,
    input  wire                      s_axi_bready,
    input  wire [`RCB_ADDR_W-1:0]    s_axi_araddr,
    input  wire                      s_axi_arvalid,
    output wire                      s_axi_arready,
    output wire [31:0]               s_axi_rdata,
    output wire [1:0]                s_axi_rresp,
    output wire                      s_axi_rvalid,
    input  wire                      s_axi_rready,
    input  wire                      wdog0_reset_req,
    input  wire                      wdog1_reset_req,
    input  wire                      brownout_reset_req,
    input  wire                      hw_service_req,
    input  wire                      hibernate_reset_req,
    input  wire                      regulator_fault_req,
    input  wire                      external_reset_pin_n,
    input  wire                      main_rail_brownout,
    input  wire                      analog_rail_brownout,
    input  wire                      core_rail_brownout,
    input  wire                      cpu_sleep_req,
    input  wire [`RCB_NPERIPH-1:0]   periph_wake_req,
    output wire                      sys_reset_pulse,
    output wire                      por_seq_pulse,
    output wire                      cpu_stall,
    output wire [`RCB_NPERIPH-1:0]   periph_clk_en
);
    localparam ST_RUN   = 1'b0;
    localparam ST_SLEEP = 1'b1;

    // write channel state
    reg                      aw_hold_r;
    reg  [`RCB_ADDR_W-1:0]   aw_addr_r;
    reg                      w_hold_r;
    reg  [31:0]              w_data_r;
    reg  [3:0]               w_strb_r;
    reg                      bvalid_r;
    reg  [1:0]               bresp_r;
    // read channel state
    reg                      rvalid_r;
    reg  [31:0]              rdata_r;
    reg  [1:0]               rresp_r;
    // configuration
    reg  [`RCB_NSRC-1:0]     beh_por_r;
    reg  [`RCB_NSRC-1:0]     beh_por_nxt;
    reg                      gate_en_r;
    reg  [`RCB_NPERIPH-1:0]  slp_mask_r;
    // event edge history
    reg  [5:0]               req_d_r;
    reg                      ext_d_r;
    reg  [2:0]               rail_d_r;
    // reset actions
    reg                      sys_pulse_r;
    reg                      por_pulse_r;
    // sleep
    reg                      state_r;
    reg                      state_nxt;
    reg  [`RCB_NPERIPH-1:0]  clk_en_r;
    reg  [`RCB_NPERIPH-1:0]  clk_en_nxt;
    reg  [31:0]              rd_mux;
    reg                      rd_ok;

    wire                     wr_go;
    wire [31:0]              wmask;
    wire [31:0]              wbits;
    wire                     wr_behav;
    wire                     wr_cause;
    wire                     wr_vestat;
    wire                     wr_slpcfg;
    wire                     wr_slpmask;
    wire                     wr_slpctl;
    wire                     wr_swrst;
    wire                     wr_known;
    wire                     rd_go;
    wire [3:0]               pin_sync;
    wire                     ext_lvl_n;
    wire [2:0]               rail_lvl;
    wire [5:0]               req_now;
    wire [5:0]               req_ev;
    wire                     ext_ev;
    wire [`RCB_NSRC-1:0]     cfg_ev;
    wire                     sw_ev;
    wire                     por_hit;
    wire                     sys_hit;
    wire                     soft_init;
    wire [`RCB_CAUSE_W-1:0]  cause_set;
    wire [`RCB_CAUSE_W-1:0]  cause_clr;
    wire [`RCB_CAUSE_W-1:0]  cause_q;
    wire [`RCB_VE_W-1:0]     ve_set;
    wire [`RCB_VE_W-1:0]     ve_clr;
    wire [`RCB_VE_W-1:0]     ve_q;
    wire [2*`RCB_NSRC-1:0]   beh_rd;
    wire                     sleep_go;
    wire                     wake;

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign wr_go         = aw_hold_r & w_hold_r & ~bvalid_r;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= {`RCB_ADDR_W{1'b0}};
            w_hold_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RCB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_known ? `RCB_RESP_OKAY : `RCB_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                    {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign wbits = w_data_r & wmask;

    assign wr_behav   = wr_go && (aw_addr_r == `RCB_OFF_BEHAV);
    assign wr_cause   = wr_go && (aw_addr_r == `RCB_OFF_CAUSE);
    assign wr_vestat  = wr_go && (aw_addr_r == `RCB_OFF_VESTAT);
    assign wr_slpcfg  = wr_go && (aw_addr_r == `RCB_OFF_SLPCFG);
    assign wr_slpmask = wr_go && (aw_addr_r == `RCB_OFF_SLPMASK);
    assign wr_slpctl  = wr_go && (aw_addr_r == `RCB_OFF_SLPCTL);
    assign wr_swrst   = wr_go && (aw_addr_r == `RCB_OFF_SWRST);
    // the size register is read-only but a write to it is harmless
    assign wr_known   = wr_behav | wr_cause | wr_vestat | wr_slpcfg |
                        wr_slpmask | wr_slpctl | wr_swrst |
                        (aw_addr_r == `RCB_OFF_SRAMSZ);

    // axi4-lite read: one cycle to rvalid
    assign rd_go         = s_axi_arvalid & ~rvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always @* begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `RCB_OFF_BEHAV:   rd_mux[2*`RCB_NSRC-1:0] = beh_rd;
            `RCB_OFF_CAUSE:   rd_mux[`RCB_CAUSE_W-1:0] = cause_q;
            `RCB_OFF_VESTAT:  rd_mux[`RCB_VE_W-1:0] = ve_q;
            `RCB_OFF_SLPCFG:  rd_mux[`RCB_SLPCFG_GATE] = gate_en_r;
            `RCB_OFF_SLPMASK: rd_mux[`RCB_NPERIPH-1:0] = slp_mask_r;
            `RCB_OFF_SLPCTL:  rd_mux[`RCB_SLPCTL_REQ] = state_r;
            `RCB_OFF_SWRST:   rd_mux = 32'h00000000;
            `RCB_OFF_SRAMSZ:  rd_mux = `RCB_SRAM_BYTES;
            default:          rd_ok = 1'b0;
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= `RCB_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_ok ? `RCB_RESP_OKAY : `RCB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // pins from outside the clock domain
    rcb_sync #(
        .W       (4),
        .RST_VAL (4'h8)
    ) u_pin_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({external_reset_pin_n, core_rail_brownout,
                analog_rail_brownout, main_rail_brownout}),
        .q    (pin_sync)
    );
    assign ext_lvl_n = pin_sync[3];
    assign rail_lvl  = pin_sync[2:0];

    // same-clock requests count on their rising edge only
    assign req_now = {regulator_fault_req, hibernate_reset_req, hw_service_req,
                      brownout_reset_req, wdog1_reset_req, wdog0_reset_req};
    assign req_ev  = req_now & ~req_d_r;
    assign ext_ev  = ext_d_r & ~ext_lvl_n;
    assign cfg_ev  = {ext_ev, req_ev[2], req_ev[1], req_ev[0]};
    assign sw_ev   = wr_swrst & wbits[`RCB_SWRST_REQ];

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_d_r  <= 6'h00;
            ext_d_r  <= 1'b1;
            rail_d_r <= 3'h0;
        end else begin
            req_d_r  <= req_now;
            ext_d_r  <= ext_lvl_n;
            rail_d_r <= rail_lvl;
        end
    end

    // full por wins when both kinds hit together
    assign por_hit = |(cfg_ev & beh_por_r);
    assign sys_hit = |(cfg_ev & ~beh_por_r) | sw_ev | (|req_ev[5:3]);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            por_pulse_r <= 1'b0;
            sys_pulse_r <= 1'b0;
        end else begin
            por_pulse_r <= por_hit;
            sys_pulse_r <= sys_hit & ~por_hit;
        end
    end
    assign por_seq_pulse   = por_pulse_r;
    assign sys_reset_pulse = sys_pulse_r;
    // cause and voltage flags are outside this re-initialisation
    assign soft_init = por_pulse_r | sys_pulse_r;

    // reset type per source: neither select bit leaves it alone
    genvar g;
    generate
        for (g = 0; g < `RCB_NSRC; g = g + 1) begin : g_beh
            always @* begin
                beh_por_nxt[g] = beh_por_r[g];
                if (wr_behav && wbits[2*g]) begin
                    beh_por_nxt[g] = 1'b1;
                end else if (wr_behav && wbits[2*g+1]) begin
                    beh_por_nxt[g] = 1'b0;
                end
            end
            assign beh_rd[2*g]   = beh_por_r[g];
            assign beh_rd[2*g+1] = ~beh_por_r[g];
        end
    endgenerate

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            beh_por_r  <= `RCB_BEH_POR_RST;
            gate_en_r  <= 1'b0;
            slp_mask_r <= `RCB_SLPMASK_RST;
        end else if (soft_init) begin
            beh_por_r  <= `RCB_BEH_POR_RST;
            gate_en_r  <= 1'b0;
            slp_mask_r <= `RCB_SLPMASK_RST;
        end else begin
            beh_por_r <= beh_por_nxt;
            if (wr_slpcfg) begin
                gate_en_r <= wbits[`RCB_SLPCFG_GATE];
            end
            if (wr_slpmask) begin
                slp_mask_r <= (slp_mask_r & ~wmask[`RCB_NPERIPH-1:0]) |
                              wbits[`RCB_NPERIPH-1:0];
            end
        end
    end

    // one flag per cause; power-on flag is the reset value
    assign cause_set[`RCB_CAUSE_EXT]   = ext_ev;
    assign cause_set[`RCB_CAUSE_POR]   = 1'b0;
    assign cause_set[`RCB_CAUSE_BOR]   = req_ev[2];
    assign cause_set[`RCB_CAUSE_WDOG]  = req_ev[0] | req_ev[1];
    assign cause_set[`RCB_CAUSE_SW]    = sw_ev;
    assign cause_set[`RCB_CAUSE_WDOG0] = req_ev[0];
    assign cause_set[`RCB_CAUSE_WDOG1] = req_ev[1];
    assign cause_set[`RCB_CAUSE_HSRV]  = req_ev[3];
    assign cause_set[`RCB_CAUSE_HIB]   = req_ev[4];
    assign cause_set[`RCB_CAUSE_LDO]   = req_ev[5];
    // software reads then clears with a mask of ones
    assign cause_clr = wr_cause ? wbits[`RCB_CAUSE_W-1:0] : {`RCB_CAUSE_W{1'b0}};

    rcb_sticky #(
        .W       (`RCB_CAUSE_W),
        .RST_VAL (`RCB_CAUSE_RST)
    ) u_cause (
        .mclk (mclk),
        .rst  (rst),
        .set  (cause_set),
        .clr  (cause_clr),
        .q    (cause_q)
    );

    // rail flags set on brownout onset, cleared only by mask write
    assign ve_set = rail_lvl & ~rail_d_r;
    assign ve_clr = wr_vestat ? wbits[`RCB_VE_W-1:0] : {`RCB_VE_W{1'b0}};

    rcb_sticky #(
        .W       (`RCB_VE_W),
        .RST_VAL (`RCB_VE_RST)
    ) u_vestat (
        .mclk (mclk),
        .rst  (rst),
        .set  (ve_set),
        .clr  (ve_clr),
        .q    (ve_q)
    );

    // sleep: wake only from a peripheral whose clock still runs
    assign sleep_go = cpu_sleep_req | (wr_slpctl & wbits[`RCB_SLPCTL_REQ]);
    assign wake     = |(periph_wake_req & clk_en_r);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_go) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
        if (soft_init) begin
            state_nxt = ST_RUN;
        end
    end

    always @* begin
        clk_en_nxt = {`RCB_NPERIPH{1'b1}};
        // without gating every peripheral keeps running
        if (state_nxt == ST_SLEEP && gate_en_r) begin
            clk_en_nxt = slp_mask_r;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r  <= ST_RUN;
            clk_en_r <= {`RCB_NPERIPH{1'b1}};
        end else begin
            state_r  <= state_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end
    assign cpu_stall     = (state_r == ST_SLEEP);
    assign periph_clk_en = clk_en_r;

endmodule // rcb_top

// [include/rcb_defines.vh]
/*
 * constants for the reset cause and behaviour controller: register offsets,
 * field positions, reset values and the fixed sram size.
 * assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
 */
`ifndef RCB_DEFINES_VH
`define RCB_DEFINES_VH

`define RCB_ADDR_W        8
`define RCB_OFF_BEHAV     8'h00
`define RCB_OFF_CAUSE     8'h04
`define RCB_OFF_VESTAT    8'h08
`define RCB_OFF_SLPCFG    8'h0C
`define RCB_OFF_SLPMASK   8'h10
`define RCB_OFF_SLPCTL    8'h14
`define RCB_OFF_SWRST     8'h18
`define RCB_OFF_SRAMSZ    8'h1C

// behaviour register: source i uses bit 2i (full por) and 2i+1 (system)
`define RCB_SRC_WDOG0     0
`define RCB_SRC_WDOG1     1
`define RCB_SRC_BOR       2
`define RCB_SRC_EXT       3
`define RCB_NSRC          4
`define RCB_BEH_POR_RST   4'h0

// cause register bits
`define RCB_CAUSE_EXT     0
`define RCB_CAUSE_POR     1
`define RCB_CAUSE_BOR     2
`define RCB_CAUSE_WDOG    3
`define RCB_CAUSE_SW      4
`define RCB_CAUSE_WDOG0   5
`define RCB_CAUSE_WDOG1   6
`define RCB_CAUSE_LDO     7
`define RCB_CAUSE_HIB     8
`define RCB_CAUSE_HSRV    9
`define RCB_CAUSE_W       10
`define RCB_CAUSE_RST     10'h002

// voltage event bits
`define RCB_VE_VDD        0
`define RCB_VE_VDDA       1
`define RCB_VE_VDDC       2
`define RCB_VE_W          3
`define RCB_VE_RST        3'h0

`define RCB_SLPCFG_GATE   0
`define RCB_SLPCTL_REQ    0
`define RCB_SWRST_REQ     0
`define RCB_NPERIPH       16
`define RCB_SLPMASK_RST   16'h0000
`define RCB_SRAM_BYTES    32'h00040000

`define RCB_RESP_OKAY     2'h0
`define RCB_RESP_SLVERR   2'h2

`endif

// [rtl/rcb_sync.v]
/*
 * three-stage synchroniser for pin inputs, one per bit.
 * assumes asynchronous pins; output moves only when stages two and three agree.
 */
`timescale 1ns/1ns
module rcb_sync #(
    parameter       W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg q_r;
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    s1_r <= RST_VAL[i];
                    s2_r <= RST_VAL[i];
                    s3_r <= RST_VAL[i];
                    q_r  <= RST_VAL[i];
                end else begin
                    s1_r <= d[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        q_r <= s3_r;
                    end
                end
            end
            assign q[i] = q_r;
        end
    endgenerate
endmodule // rcb_sync

// [rtl/rcb_sticky.v]
/*
 * sticky flag bank: hardware sets, software clears by mask.
 * assumes set and clear come from logic on mclk.
 */
`timescale 1ns/1ns
module rcb_sticky #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_flag
            reg flag_r;
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    flag_r <= RST_VAL[i];
                end else if (set[i]) begin
                    // set beats a clear in the same cycle
                    flag_r <= 1'b1;
                end else if (clr[i]) begin
                    flag_r <= 1'b0;
                end
            end
            assign q[i] = flag_r;
        end
    endgenerate
endmodule // rcb_sticky

// [verification/rcb_assertions.sv]
/* checker for rcb_top: reset pulses, sleep control, read channel.
   assumes only the top ports, one mclk domain, rst active high. */
`timescale 1ns/1ns
`include "rcb_defines.vh"
module rcb_assertions (
    input wire                    mclk,
    input wire                    rst,
    input wire                    s_axi_arready,
    input wire                    s_axi_rvalid,
    input wire                    s_axi_rready,
    input wire                    wdog0_reset_req,
    input wire                    hw_service_req,
    input wire                    cpu_sleep_req,
    input wire [`RCB_NPERIPH-1:0] periph_wake_req,
    input wire                    sys_reset_pulse,
    input wire                    por_seq_pulse,
    input wire                    cpu_stall,
    input wire [`RCB_NPERIPH-1:0] periph_clk_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // an issued reset reinitialises sleep state, so those cycles are excluded
    sequence s_sleep_go;
        $rose(cpu_sleep_req) && !cpu_stall && !sys_reset_pulse && !por_seq_pulse;
    endsequence
    sequence s_wake;
        cpu_stall && (|(periph_wake_req & periph_clk_en));
    endsequence
    sequence s_idle_asleep;
        cpu_stall && !(|(periph_wake_req & periph_clk_en)) && !sys_reset_pulse && !por_seq_pulse;
    endsequence
    a_sleep_entry: assert property (s_sleep_go |=> cpu_stall)
        else $error("sleep request did not stall cpu");
    a_sleep_hold: assert property (s_idle_asleep |=> cpu_stall)
        else $error("cpu left sleep without wake");
    a_wake_exit: assert property (s_wake |=> !cpu_stall)
        else $error("enabled wake did not resume cpu");
    a_run_clocks: assert property (!cpu_stall |-> periph_clk_en == 16'hFFFF)
        else $error("peripheral clock gated in run");
    a_pulse_excl: assert property (!(sys_reset_pulse && por_seq_pulse))
        else $error("both reset kinds issued");
    a_wdog_reset: assert property ($rose(wdog0_reset_req) |=> sys_reset_pulse || por_seq_pulse)
        else $error("watchdog event issued no reset");
    a_service_reset: assert property ($rose(hw_service_req) |=> sys_reset_pulse || por_seq_pulse)
        else $error("service event issued no reset");
    a_read_busy: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after taken");
endmodule // rcb_assertions
bind rcb_top rcb_assertions u_rcb_assertions (.*);

// [verification/testbench.sv]
/* self-checking bench for rcb_top over axi4-lite.
   assumes rcb_defines.vh offsets; events driven one at a time. */
`timescale 1ns/1ns
`include "rcb_defines.vh"
module testbench;
    logic mclk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_sleep_req = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] periph_wake_req = 16'h0000, periph_clk_en;
    logic sys_reset_pulse, por_seq_pulse, cpu_stall;
    logic [10:0] ev = 11'h000;
    // pin is active low, so its event bit is inverted
    wire wdog0_reset_req = ev[0], wdog1_reset_req = ev[1], brownout_reset_req = ev[2];
    wire external_reset_pin_n = ~ev[3], hw_service_req = ev[4];
    wire hibernate_reset_req = ev[5], regulator_fault_req = ev[6];
    wire main_rail_brownout = ev[8], analog_rail_brownout = ev[9], core_rail_brownout = ev[10];
    int n_errors = 0, check_count = 0, n_sys = 0, n_por = 0, s, p, k, g;
    logic [31:0] rd, beh, cause, ve, m;
    rcb_top u_rcb_top (.*);
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (sys_reset_pulse === 1'b1) n_sys++;
        if (por_seq_pulse === 1'b1) n_por++;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits end only on the answer; the watchdog catches a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [31:0] beh_next(input logic [31:0] cur, input logic [31:0] d);
        beh_next = cur;
        for (int i = 0; i < 4; i++)
            if (d[2*i]) beh_next[2*i+:2] = 2'b01;
            else if (d[2*i+1]) beh_next[2*i+:2] = 2'b10;
    endfunction
    function automatic logic [31:0] cause_of(input int e);
        case (e)
            0: cause_of = 32'h00000028;
            1: cause_of = 32'h00000048;
            2: cause_of = 32'h00000004;
            3: cause_of = 32'h00000001;
            4: cause_of = 32'h00000200;
            5: cause_of = 32'h00000100;
            6: cause_of = 32'h00000080;
            default: cause_of = 32'h00000010;
        endcase
    endfunction
    // 7 is a software reset; rails need time to cross the synchroniser
    task automatic fire(input int e);
        logic [1:0] r;
        if (e == 7) wr(`RCB_OFF_SWRST, 32'h00000001, r);
        else begin
            @(posedge mclk);
            ev[e] <= 1'b1;
            repeat (4) @(posedge mclk);
            ev[e] <= 1'b0;
        end
        repeat (8) @(posedge mclk);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        wrap_up;
    end
    initial begin
        k = $urandom(97);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdr(`RCB_OFF_CAUSE, rd, rs); chk_w(rd, 32'h00000002);
        rdr(`RCB_OFF_VESTAT, rd, rs); chk_w(rd, 32'h00000000);
        rdr(`RCB_OFF_BEHAV, rd, rs); chk_w(rd, 32'h000000AA);
        rdr(`RCB_OFF_SRAMSZ, rd, rs); chk_w(rd, `RCB_SRAM_BYTES);
        rdr(8'h40, rd, rs); chk_w({30'h0, rs}, {30'h0, `RCB_RESP_SLVERR});
        wr(8'h40, 32'hFFFFFFFF, rs); chk_w({30'h0, rs}, {30'h0, `RCB_RESP_SLVERR});
        $display("test reset values done");
        beh = 32'h000000AA;
        for (k = 0; k < 12; k++) begin
            m = (k == 0) ? 32'h0 : ($urandom & 32'h000000FF);
            // a low strobe on the byte must mask the whole write
            s_axi_wstrb <= (k == 1) ? 4'hE : 4'hF;
            wr(`RCB_OFF_BEHAV, m, rs);
            beh = beh_next(beh, (k == 1) ? 32'h0 : m);
            rdr(`RCB_OFF_BEHAV, rd, rs); chk_w(rd, beh);
        end
        $display("test behaviour done");
        wr(`RCB_OFF_CAUSE, 32'h000003FF, rs);
        cause = 32'h0;
        for (k = 0; k < 16; k++) begin
            m = $urandom & 32'h000000FF;
            wr(`RCB_OFF_BEHAV, m, rs);
            beh = beh_next(beh, m);
            s = n_sys;
            p = n_por;
            fire(k % 8);
            g = ((k % 8) < 4) ? beh[2*(k%8)] : 0;
            chk_w(32'(n_por - p), 32'(g));
            chk_w(32'(n_sys - s), 32'(1 - g));
            beh = 32'h000000AA;
            cause = cause | cause_of(k % 8);
            rdr(`RCB_OFF_CAUSE, rd, rs); chk_w(rd, cause);
            rdr(`RCB_OFF_BEHAV, rd, rs); chk_w(rd, beh);
            if (k % 3 == 2) begin
                m = $urandom & 32'h000003FF;
                wr(`RCB_OFF_CAUSE, m, rs);
                cause = cause & ~m;
                rdr(`RCB_OFF_CAUSE, rd, rs); chk_w(rd, cause);
            end
        end
        $display("test reset causes done");
        ve = 32'h0;
        for (k = 8; k < 11; k++) begin
            fire(k);
            ve[k-8] = 1'b1;
            rdr(`RCB_OFF_VESTAT, rd, rs); chk_w(rd, ve);
        end
        fire(7);
        rdr(`RCB_OFF_VESTAT, rd, rs); chk_w(rd, ve);
        m = $urandom & 32'h00000007;
        wr(`RCB_OFF_VESTAT, m, rs);
        ve = ve & ~m;
        rdr(`RCB_OFF_VESTAT, rd, rs); chk_w(rd, ve);
        $display("test voltage events done");
        for (g = 0; g < 2; g++) begin
            m = ($urandom & 32'h0000FFFC) | 32'h00000002;
            wr(`RCB_OFF_SLPMASK, m, rs);
            wr(`RCB_OFF_SLPCFG, 32'(g), rs);
            // pin request in one pass, register request in the other
            if (g == 0) begin
                @(posedge mclk);
                cpu_sleep_req <= 1'b1;
                @(posedge mclk);
                cpu_sleep_req <= 1'b0;
            end else wr(`RCB_OFF_SLPCTL, 32'h00000001, rs);
            repeat (2) @(posedge mclk);
            chk_b(cpu_stall, 1'b1);
            chk_w({16'h0, periph_clk_en}, g ? m : 32'h0000FFFF);
            rdr(`RCB_OFF_SLPCTL, rd, rs); chk_w(rd, 32'h00000001);
            periph_wake_req <= 16'h0001;
            repeat (2) @(posedge mclk);
            chk_b(cpu_stall, g[0]);
            periph_wake_req <= 16'h0002;
            repeat (2) @(posedge mclk);
            chk_b(cpu_stall, 1'b0);
            periph_wake_req <= 16'h0000;
        end
        $display("test sleep done");
        wrap_up;
    end
endmodule // testbench
